/* File: design/spi_eeprom_command_regs.svh */
// Constants of the serial EEPROM command core: opcodes, status fields, timing
`ifndef SPI_EEPROM_COMMAND_REGS_SVH
`define SPI_EEPROM_COMMAND_REGS_SVH
// Opcodes
`define OP_LATCH_SET    8'h06
`define OP_LATCH_CLEAR  8'h04
`define OP_STATUS_READ  8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_MEM_READ     8'h03
`define OP_MEM_WRITE    8'h02
// Status and control bit positions
`define ST_BUSY_BIT     0
`define ST_LATCH_BIT    1
`define ST_GUARD_LO_BIT 2
`define ST_GUARD_HI_BIT 3
`define ST_LOCK_BIT     4
`define ST_SELECT_BIT   6
`define ST_PEN_BIT      7
// Reset values of the stored fields
`define GUARD_RST       2'h0
`define PEN_RST         1'h0
`define LOCK_RST        1'h0
`define PIN_IDLE        4'hF
// Sizes
`define PAGE_BYTES      64
`define FIFO_DEPTH      16
// Internal write cycle, longest time, and core clock period
`define WRITE_CYCLE_NS  5000000
`define CLK_PERIOD_NS   8
`endif

/* File: design/spi_eeprom_command_pkg.sv */
// Types shared by the serial EEPROM command core
package spi_eeprom_command_pkg;
  // Frame phases, one-hot
  typedef enum logic [4:0] {
    ST_OPCODE     = 5'h01,
    ST_ADDR       = 5'h02,
    ST_DATA       = 5'h04,
    ST_STATUS_OUT = 5'h08,
    ST_IGNORE     = 5'h10
  } frame_state_type;
  // One byte handed to the array programmer
  typedef struct packed {
    logic        id_page;
    logic [13:0] addr;
    logic [7:0]  data;
  } prog_word_type;
  // Pins seen through the synchroniser
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } pin_type;
endpackage

/* File: design/spi_eeprom_command_core.sv */
// Command, status and write-control core of a 16K x 8 SPI serial EEPROM
// Behaviour
// - Only SPI modes (0,0) and (1,1) supported
// - Decode six 8-bit opcodes
// - First eight bits form instruction; ignore others
// - Busy bit 0 set during write cycle
// - Write latch set/cleared by latch opcodes
// - Two guard bits select protected range
// - Pin low and enable bit block status writes
// - Latch, guard, pin combine to allow writes
// - Page select routes to id page, self-clears
// - Page lock makes id page read-only until reset
// - Select and lock together: neither written
// - Bit 5 reads zero; older: 6,4 zero
// - Write latch cleared after reset
// - Memory writes only outside guarded range
// - Latch set only at chip select rise
// - 16-bit address, low 14 bits used
// - Program at select rise; busy ignores most
// - Up to 64 bytes, wrap inside page
// - Write cycle end clears write latch
// - Id page uses address bits 5..0 only
// - Reject id write: full guard or lock
// - Sample input rising, shift output falling
// - Output off while chip select high
// - Status write touches bits 2,3,4,6,7 only
`timescale 1ns/100ps
`include "spi_eeprom_command_regs.svh"

// ****************************************************************
// Parameterised FIFO between page buffer and programmer
// ****************************************************************
module fifo_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             reset_n_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // Honest full and empty from the fill count
  assign in_ready_out  = (count_q != (AW+1)'(DEPTH));
  assign out_valid_out = (count_q != '0);
  assign out_data_out  = mem_q[rd_ptr_q];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // Storage
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  // Pointers and count
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// ****************************************************************
// Command core
// ****************************************************************
module spi_eeprom_command_core
  import spi_eeprom_command_pkg::*;
#(
  parameter int unsigned WC_CYCLES   = `WRITE_CYCLE_NS / `CLK_PERIOD_NS,
  parameter bit          HAS_ID_PAGE = 1'b1
) (
  // Clock and reset
  input  wire logic    core_clk_in,
  input  wire logic    reset_n_in,
  // SPI pins and write protect pin
  input  wire logic    cs_n_in,
  input  wire logic    sck_in,
  input  wire logic    si_in,
  input  wire logic    wp_n_in,
  output logic         so_out,
  output logic         so_oe_out,
  // Byte stream to the array programmer
  output prog_word_type prog_word_out,
  output logic         prog_valid_out,
  input  wire logic    prog_ready_in,
  // Observation
  output logic [7:0]   status_out,
  output logic         busy_out
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  pin_type         meta_q, sync_q, prev_q;
  frame_state_type state_q;
  logic [2:0]      bit_cnt_q;
  logic [7:0]      shift_q, opcode_q, data_q, so_shift_q;
  logic [15:0]     addr_q;
  logic            addr_byte_q, got_data_q;
  logic [2:0]      out_cnt_q;
  logic [7:0]      page_mem_q [`PAGE_BYTES];
  logic [63:0]     loaded_q;
  logic [5:0]      ptr_q, walk_idx_q;
  logic [7:0]      walk_base_q;
  logic            walk_q, walk_id_q, pend_q;
  logic [19:0]     timer_q;
  logic            wr_latch_q, pen_q, lock_q, sel_q;
  logic [1:0]      guard_q;
  logic            sck_rise, sck_fall, cs_fall, cs_rise, byte_done;
  logic [7:0]      shift_next, status_view;
  logic            at_boundary, in_data, acc_set, acc_clear, acc_swr, acc_mwr;
  logic            hw_protect, wr_guarded, wc_done, sel_clear;
  logic            fifo_in_ready, fifo_out_valid, fifo_out_ready, walk_adv;
  prog_word_type   fifo_in_word, fifo_out_word;

  // Address inside the guarded range
  function automatic logic in_guard(input logic [1:0] g, input logic [13:0] a);
    unique case (g)
      2'h0: in_guard = 1'b0;
      2'h1: in_guard = (a[13:12] == 2'h3);
      2'h2: in_guard = a[13];
      2'h3: in_guard = 1'b1;
    endcase
  endfunction

  // ****************************************************************
  // Pin synchroniser and edge detection
  // ****************************************************************
  // Two flops on every pin, third for edges
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      meta_q <= `PIN_IDLE;
      sync_q <= `PIN_IDLE;
      prev_q <= `PIN_IDLE;
    end else begin
      meta_q <= '{cs_n: cs_n_in, sck: sck_in, si: si_in, wp_n: wp_n_in};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign sck_rise   = sync_q.sck & ~prev_q.sck & ~sync_q.cs_n;
  assign sck_fall   = ~sync_q.sck & prev_q.sck & ~sync_q.cs_n;
  assign cs_fall    = ~sync_q.cs_n & prev_q.cs_n;
  assign cs_rise    = sync_q.cs_n & ~prev_q.cs_n;
  assign shift_next = {shift_q[6:0], sync_q.si};
  assign byte_done  = sck_rise & (bit_cnt_q == 3'h7);

  // ****************************************************************
  // Frame decode
  // ****************************************************************
  // Bit counting, opcode, address and first data byte
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || cs_fall) begin
      state_q     <= ST_OPCODE;
      bit_cnt_q   <= '0;
      addr_byte_q <= 1'b0;
      got_data_q  <= 1'b0;
      if (!reset_n_in) begin
        shift_q  <= '0;
        opcode_q <= '0;
        addr_q   <= '0;
        data_q   <= '0;
      end
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 1'b1;
      shift_q   <= shift_next;
      if (byte_done) begin
        unique case (state_q)
          ST_OPCODE: begin
            opcode_q <= shift_next;
            if (pend_q && shift_next != `OP_STATUS_READ) begin
              state_q <= ST_IGNORE;
            end else begin
              unique case (shift_next)
                `OP_MEM_READ, `OP_MEM_WRITE: state_q <= ST_ADDR;
                `OP_STATUS_READ: state_q <= ST_STATUS_OUT;
                `OP_STATUS_WRITE, `OP_LATCH_SET, `OP_LATCH_CLEAR: state_q <= ST_DATA;
                default: state_q <= ST_IGNORE;
              endcase
            end
          end
          ST_ADDR: begin
            addr_q      <= {addr_q[7:0], shift_next};
            addr_byte_q <= 1'b1;
            if (addr_byte_q) begin
              state_q <= ST_DATA;
            end
          end
          ST_DATA: begin
            got_data_q <= 1'b1;
            if (!got_data_q) begin
              data_q <= shift_next;
            end
          end
          ST_STATUS_OUT, ST_IGNORE: begin
            state_q <= state_q;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Page buffer loading
  // ****************************************************************
  assign in_data = (state_q == ST_DATA) & (opcode_q == `OP_MEM_WRITE);

  // Byte storage of the page being loaded
  always_ff @(posedge core_clk_in) begin
    if (byte_done && in_data) begin
      page_mem_q[ptr_q] <= shift_next;
    end
  end

  // Loaded mask and in-page pointer
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      loaded_q <= '0;
      ptr_q    <= '0;
    end else if (byte_done) begin
      if (state_q == ST_OPCODE && !pend_q && shift_next == `OP_MEM_WRITE) begin
        loaded_q <= '0;
      end else if (state_q == ST_ADDR && addr_byte_q) begin
        ptr_q <= shift_next[5:0];
      end else if (in_data) begin
        loaded_q[ptr_q] <= 1'b1;
        ptr_q <= ptr_q + 1'b1;
      end
    end
  end

  // ****************************************************************
  // Acceptance at the end of a frame
  // ****************************************************************
  assign at_boundary = cs_rise & (bit_cnt_q == 3'h0) & (state_q == ST_DATA);
  // hardware protection from pin and enable bit
  assign hw_protect  = pen_q & ~sync_q.wp_n;
  // id page refused on lock or full guard
  // guard range lookup on 14-bit address
  assign wr_guarded  = sel_q ? (lock_q | in_guard(guard_q, {8'h00, addr_q[5:0]}))
                             : in_guard(guard_q, addr_q[13:0]);
  // latch opcodes act on select rising
  assign acc_set     = at_boundary & ~got_data_q & (opcode_q == `OP_LATCH_SET);
  assign acc_clear   = at_boundary & ~got_data_q & (opcode_q == `OP_LATCH_CLEAR);
  // status write needs latch and no protection
  assign acc_swr     = at_boundary & got_data_q & (opcode_q == `OP_STATUS_WRITE)
                       & wr_latch_q & ~hw_protect;
  // memory write needs latch and unguarded address
  assign acc_mwr     = at_boundary & got_data_q & in_data & wr_latch_q & ~wr_guarded;
  // select clears after a read or write frame
  assign sel_clear   = cs_rise & (state_q == ST_ADDR || state_q == ST_DATA)
                       & (opcode_q == `OP_MEM_READ || opcode_q == `OP_MEM_WRITE);

  // ****************************************************************
  // Status and control register
  // ****************************************************************
  // latch cleared at reset
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      wr_latch_q <= 1'b0;
    end else if (acc_set) begin
      wr_latch_q <= 1'b1;
    end else if (acc_clear || wc_done) begin
      wr_latch_q <= 1'b0;
    end
  end

  // Stored guard, enable and lock fields, volatile select
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      guard_q <= `GUARD_RST;
      pen_q   <= `PEN_RST;
      lock_q  <= `LOCK_RST;
      sel_q   <= 1'b0;
    end else if (acc_swr) begin
      pen_q   <= data_q[`ST_PEN_BIT];
      guard_q <= {data_q[`ST_GUARD_HI_BIT], data_q[`ST_GUARD_LO_BIT]};
      // select and lock together are refused
      if (HAS_ID_PAGE && !(data_q[`ST_SELECT_BIT] && data_q[`ST_LOCK_BIT])) begin
        sel_q  <= data_q[`ST_SELECT_BIT];
        lock_q <= lock_q | data_q[`ST_LOCK_BIT];
      end
    end else if (sel_clear) begin
      sel_q <= 1'b0;
    end
  end

  // bit 5 zero, id fields zero without id page
  // busy bit reflects the write cycle
  assign status_view = {pen_q, sel_q & HAS_ID_PAGE, 1'b0, lock_q & HAS_ID_PAGE,
                        guard_q, wr_latch_q, pend_q};

  // ****************************************************************
  // Internal write cycle
  // ****************************************************************
  assign walk_adv = walk_q & (fifo_in_ready | ~loaded_q[walk_idx_q]);
  assign wc_done  = pend_q & ~walk_q & (timer_q == '0) & ~fifo_out_valid & ~prog_valid_out;

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      pend_q      <= 1'b0;
      walk_q      <= 1'b0;
      walk_idx_q  <= '0;
      walk_base_q <= '0;
      walk_id_q   <= 1'b0;
      timer_q     <= '0;
    end else if (acc_mwr) begin
      pend_q      <= 1'b1;
      walk_q      <= 1'b1;
      walk_idx_q  <= '0;
      walk_base_q <= addr_q[13:6];
      walk_id_q   <= sel_q;
    end else if (acc_swr) begin
      pend_q  <= 1'b1;
      timer_q <= 20'(WC_CYCLES);
    end else begin
      if (walk_adv) begin
        walk_idx_q <= walk_idx_q + 1'b1;
        if (walk_idx_q == 6'h3F) begin
          walk_q  <= 1'b0;
          timer_q <= 20'(WC_CYCLES);
        end
      end else if (timer_q != '0) begin
        timer_q <= timer_q - 1'b1;
      end
      if (wc_done) begin
        pend_q <= 1'b0;
      end
    end
  end

  // id page addressed by offset alone
  assign fifo_in_word = '{id_page: walk_id_q,
                          addr:    walk_id_q ? {8'h00, walk_idx_q} : {walk_base_q, walk_idx_q},
                          data:    page_mem_q[walk_idx_q]};

  // Loaded bytes wait here for the programmer
  fifo_buffer #(
    .WIDTH ($bits(prog_word_type)),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in   (core_clk_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (walk_q & loaded_q[walk_idx_q]),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (fifo_in_word),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (fifo_out_word)
  );

  assign fifo_out_ready = ~prog_valid_out | prog_ready_in;

  // Registered output stage of the byte stream
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      prog_valid_out <= 1'b0;
      prog_word_out  <= '0;
    end else if (fifo_out_ready) begin
      prog_valid_out <= fifo_out_valid;
      if (fifo_out_valid) begin
        prog_word_out <= fifo_out_word;
      end
    end
  end

  // ****************************************************************
  // Serial output
  // ****************************************************************
  // status shifted out on falling edges
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || cs_fall) begin
      out_cnt_q  <= '0;
      so_shift_q <= '0;
      so_out     <= 1'b0;
    end else if (sck_fall && state_q == ST_STATUS_OUT) begin
      out_cnt_q <= out_cnt_q + 1'b1;
      if (out_cnt_q == 3'h0) begin
        so_out     <= status_view[7];
        so_shift_q <= {status_view[6:0], 1'b0};
      end else begin
        so_out     <= so_shift_q[7];
        so_shift_q <= {so_shift_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || sync_q.cs_n || cs_fall) begin
      so_oe_out <= 1'b0;
    end else if (sck_fall && state_q == ST_STATUS_OUT) begin
      so_oe_out <= 1'b1;
    end
  end

  // Observation copies
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      status_out <= '0;
      busy_out   <= 1'b0;
    end else begin
      status_out <= status_view;
      busy_out   <= pend_q;
    end
  end
endmodule

/* File: tb/spi_eeprom_command_core_assertions.sv */
// Port checker of the serial EEPROM command core
`timescale 1ns/100ps
module spi_eeprom_command_checker
  import spi_eeprom_command_pkg::*;
#(
  parameter int unsigned WC_CYCLES = 50
) (
  // Clock and reset
  input  wire logic          core_clk_in,
  input  wire logic          reset_n_in,
  // SPI side
  input  wire logic          cs_n_in,
  input  wire logic          so_oe_out,
  // Programmer stream
  input  wire prog_word_type prog_word_out,
  input  wire logic          prog_valid_out,
  input  wire logic          prog_ready_in,
  // Observation
  input  wire logic [7:0]    status_out,
  input  wire logic          busy_out
);
  int unsigned busy_len_q;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // Length of the running write cycle
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || !busy_out) begin
      busy_len_q <= 0;
    end else begin
      busy_len_q <= busy_len_q + 1;
    end
  end

  sequence cs_idle;
    cs_n_in [*8];
  endsequence
  sequence word_stalled;
    prog_valid_out && !prog_ready_in;
  endsequence

  // ******************************
  // Assertions
  // ******************************
  a_oe_idle_off: assert property (cs_idle |-> !so_oe_out)
    else $error("serial output enabled while deselected");
  a_word_held: assert property (word_stalled |=> prog_valid_out && $stable(prog_word_out))
    else $error("stalled word changed or dropped");
  a_busy_copy: assert property (status_out[0] == busy_out)
    else $error("status busy bit differs from busy output");
  a_bit5_zero: assert property (status_out[5] == 1'b0)
    else $error("status bit 5 not zero");
  a_busy_min_len: assert property ($fell(busy_out) |-> busy_len_q >= WC_CYCLES)
    else $error("write cycle shorter than its timer");
  a_latch_end_clear: assert property ($fell(busy_out) |-> ##[0:2] !status_out[1])
    else $error("write latch kept after write cycle");
  a_accept_in_busy: assert property (prog_valid_out && prog_ready_in |=> busy_out)
    else $error("busy dropped with programming pending");
  a_busy_after_cs: assert property ($rose(busy_out) |-> cs_n_in && $past(cs_n_in, 3))
    else $error("write cycle began with chip select low");
  a_latch_after_cs: assert property ($rose(status_out[1]) |-> cs_n_in && $past(cs_n_in, 3))
    else $error("write latch set before chip select rose");
  a_lock_sel_apart: assert property ($rose(status_out[4]) |-> !$rose(status_out[6]))
    else $error("page select and lock set together");
  a_lock_kept: assert property (status_out[4] |=> status_out[4])
    else $error("page lock cleared");
endmodule

bind spi_eeprom_command_core spi_eeprom_command_checker #(.WC_CYCLES(WC_CYCLES)) u_checker (
  .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .cs_n_in(cs_n_in),
  .so_oe_out(so_oe_out), .prog_word_out(prog_word_out), .prog_valid_out(prog_valid_out),
  .prog_ready_in(prog_ready_in), .status_out(status_out), .busy_out(busy_out));

/* File: tb/spi_host_model.sv */
// Host SPI controller model that frames commands toward the device
`timescale 1ns/100ps
module spi_host_model (
  // SPI pins
  output logic      cs_n_out,
  output logic      sck_out,
  output logic      si_out,
  input  wire logic so_in
);
  localparam realtime HALF = 62.5;

  // Idle pins
  initial begin
    cs_n_out = 1'b1;
    sck_out  = 1'b0;
    si_out   = 1'b0;
  end

  // mode 0 or 3, MSB first
  task automatic xfer(input bit cpol, input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    sck_out <= cpol;
    #HALF;
    cs_n_out <= 1'b0;
    #HALF;
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        sck_out <= 1'b0;
        si_out  <= tx[i][k];
        #HALF;
        sck_out <= 1'b1;
        b[k] = so_in;
        #HALF;
      end
      rx.push_back(b);
    end
    sck_out <= cpol;
    #HALF;
    // frame closed by chip select rise
    cs_n_out <= 1'b1;
    si_out   <= ~si_out;
    #(2 * HALF);
  endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench of the serial EEPROM command core
`timescale 1ns/100ps
module tb;
  import spi_eeprom_command_pkg::*;
  localparam int WC = 600;
  // Design signals
  logic          core_clk_in   = 1'b0;
  logic          reset_n_in    = 1'b0;
  logic          wp_n_in       = 1'b1;
  logic          prog_ready_in = 1'b0;
  logic          cs_n, sck, si, so_out, so_oe_out, prog_valid_out, busy_out;
  prog_word_type prog_word_out;
  logic [7:0]    status_out;
  wire           so_line = so_oe_out ? so_out : 1'bz;
  // Bench model state
  int            n_mismatch = 0;
  int            checked    = 0;
  int            guard, pen, lock, sel, wlatch;
  prog_word_type exp_q[$];
  prog_word_type e;
  logic [22:0]   m;
  logic [7:0]    bad[4] = '{8'h00, 8'h07, 8'h86, 8'hFF};
  logic [15:0]   adr[3] = '{16'h1FFF, 16'h2000, 16'h3000};

  always #4 core_clk_in = ~core_clk_in;

  spi_eeprom_command_core #(.WC_CYCLES(WC), .HAS_ID_PAGE(1'b1)) dut (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .cs_n_in(cs_n), .sck_in(sck),
    .si_in(si), .wp_n_in(wp_n_in), .so_out(so_out), .so_oe_out(so_oe_out),
    .prog_word_out(prog_word_out), .prog_valid_out(prog_valid_out),
    .prog_ready_in(prog_ready_in), .status_out(status_out), .busy_out(busy_out));
  spi_host_model host (.cs_n_out(cs_n), .sck_out(sck), .si_out(si), .so_in(so_line));

  // ******************************
  // Comparison and verdict
  // ******************************
  task automatic check(input logic [22:0] seen, input logic [22:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (n_mismatch == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  function automatic logic [7:0] exp_st();
    return {pen[0], sel[0], 1'b0, lock[0], guard[1:0], wlatch[0], 1'b0};
  endfunction

  // ******************************
  // Command frames
  // ******************************
  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    host.xfer(1'($urandom_range(0, 1)), tx, rx);
  endtask

  task automatic send(input logic [7:0] tx[$]);
    logic [7:0] rx[$];
    frame(tx, rx);
  endtask

  // Status polled until ready, then compared whole
  task automatic poll(input bit busy_exp);
    logic [7:0] rx[$];
    frame({8'h05, 8'h00}, rx);
    check(rx[1][0], busy_exp);
    repeat (20) if (rx[1][0] !== 1'b0) frame({8'h05, 8'h00}, rx);
    check(rx[1], exp_st());
    check(status_out, exp_st());
    check(23'(exp_q.size()), 23'h0);
  endtask

  task automatic status_write_cmd(input logic [7:0] v);
    send({8'h06});
    wlatch = 1;
    send({8'h01, v});
    if (pen[0] && !wp_n_in) begin
      poll(0);
    end else begin
      guard = v[3:2];
      pen = v[7];
      if (!(v[6] && v[4])) begin
        sel = v[6];
        lock = lock | v[4];
      end
      wlatch = 0;
      poll(1);
    end
  endtask

  // page write, latch set sent after it, ignored while busy
  task automatic write(input logic [15:0] a, input int n, input bit latch);
    logic [7:0] tx[$];
    logic [7:0] pg[64];
    bit         ld[64];
    bit         ok;
    int         off;
    if (latch) begin
      send({8'h06});
      wlatch = 1;
    end
    tx = {8'h02, a[15:8], a[7:0]};
    off = a[5:0];
    for (int i = 0; i < n; i++) begin
      pg[off] = 8'($urandom());
      ld[off] = 1'b1;
      tx.push_back(pg[off]);
      off = (off + 1) % 64;
    end
    ok = sel ? !(lock || guard == 3) :
         !(guard == 3 || (guard == 2 && a[13]) || (guard == 1 && a[13:12] == 2'b11));
    ok = ok && wlatch;
    for (int i = 0; i < 64; i++) if (ok && ld[i]) exp_q.push_back({sel[0], a[13:6], 6'(i), pg[i]});
    send(tx);
    send({8'h06});
    wlatch = !ok;
    sel = 0;
    poll(ok);
  endtask

  // Programmer side with random stalls, words checked on acceptance
  always @(posedge core_clk_in) begin
    prog_ready_in <= ($urandom_range(0, 3) == 0);
    if (reset_n_in && prog_valid_out && prog_ready_in) begin
      if (exp_q.size() == 0) check(23'h1, 23'h0);
      else begin
        e = exp_q.pop_front();
        m = e.id_page ? 23'h403FFF : 23'h7FFFFF;
        check(prog_word_out & m, e & m);
      end
    end
  end

  // ******************************
  // Main sequence
  // ******************************
  initial begin
    void'($urandom(32'h0f30ec26));
    repeat (5) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    poll(0);
    write(16'h0100, 1, 0);
    // unknown codes leave latch, clear drops it
    send({8'h06});
    wlatch = 1;
    foreach (bad[i]) send({bad[i], 8'h00});
    poll(0);
    send({8'h04});
    wlatch = 0;
    poll(0);
    // every guard code at block edges
    for (int g = 0; g < 4; g++) begin
      status_write_cmd(8'(g << 2));
      foreach (adr[i]) write(adr[i], 2, 1);
    end
    // wrap inside page, top bits ignored; bits 0,1,5 dropped
    status_write_cmd(8'h27);
    write(16'hDF3C, 70, 1);
    status_write_cmd(8'h80);
    @(posedge core_clk_in);
    wp_n_in <= 1'b0;
    status_write_cmd(8'h0C);
    @(posedge core_clk_in);
    wp_n_in <= 1'b1;
    status_write_cmd(8'h00);
    // id page write and read clear select
    status_write_cmd(8'h40);
    write(16'hFFC5, 3, 1);
    status_write_cmd(8'h40);
    send({8'h03, 8'h00, 8'h00, 8'h00});
    sel = 0;
    poll(0);
    status_write_cmd(8'h50);
    status_write_cmd(8'h10);
    status_write_cmd(8'h40);
    write(16'h0005, 1, 1);
    results();
  end

  // Watchdog against a hang, about 90000 core cycles
  initial begin
    #720000;
    n_mismatch++;
    results();
  end
endmodule
